// ### smc_regs.sv
// configuration register bank of a three-axis motion sensor
// Notes on behaviour
// - range codes select 2g, 4g, 8g, 16g
// - bandwidth code maps 7.81 Hz to 1000 Hz
// - three mode bits decode four power modes
// - only permitted power transitions are used; the code only rejects illegal mode codes, not transitions
// - nap code sets duty-cycle sleep length
// - first profile denies buffer in low modes
// - second profile keeps buffer, full-speed writes
// - timebase select picks event or equidistant
// - raw select gives unfiltered output samples
// - low byte read freezes high byte
// - only 0xB6 write starts a reset
// - after delay all settings return default
// - reset trigger accepted in every mode
// - group-0 bits enable four engines
// - slope enabled per axis, bit3 reserved
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_regs
    import smc_pkg::*;
#(
    parameter int RST_CYC = `SMC_RST_DELAY_CYC
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rstn,
    input  wire logic [7:0] i_addr,         // register address
    input  wire logic [7:0] i_wdata,        // write data
    input  wire logic       i_wr,           // write strobe
    input  wire logic       i_rd,           // read strobe
    input  wire logic       i_lo_rd,        // axis low byte read
    input  wire logic       i_hi_rd,        // axis high byte read
    input  wire logic [7:0] i_hi_filt,      // filtered high byte
    input  wire logic [7:0] i_hi_raw,       // unfiltered high byte
    output logic      [7:0] o_rdata,        // read data
    output logic      [1:0] o_span_sel,     // 0:2g 1:4g 2:8g 3:16g
    output logic      [3:0] o_bw_sel,       // 0:7.81 Hz .. 7:1000 Hz
    output logic      [1:0] o_mode,         // decoded power mode
    output logic      [3:0] o_nap_sel,      // 0:0.5 ms .. 10:1 s
    output logic            o_buf_access,   // sample buffer reachable
    output logic            o_slow_writes,  // writes must be slowed
    output logic            o_equidistant,  // equidistant timebase
    output logic      [7:0] o_hi_byte,      // axis high byte out
    output logic            o_rst_busy,     // soft reset in progress
    output logic      [3:0] o_eng_en,       // level, orient, stap, dtap
    output logic      [2:0] o_slope_en      // slope z, y, x
);
    // =====================================================================
    // stored registers
    logic [7:0] span_r;      // range field
    logic [7:0] filt_r;      // bandwidth field
    logic [7:0] pwr_r;       // mode bits and nap
    logic [7:0] prof_r;      // profile and timebase
    logic [7:0] ofmt_r;      // raw select, lock disable
    logic [7:0] eng_r;       // engine enables
    logic [7:0] rdata_r;     // read data
    smc_rst_state_t rs_r;    // soft reset state
    logic [15:0] rcnt_r;     // soft reset delay counter

    // =====================================================================
    // decode functions
    function automatic logic span_ok(input logic [3:0] c);
        span_ok = (c == `SMC_SPAN_2G) | (c == `SMC_SPAN_4G) |
                  (c == `SMC_SPAN_8G) | (c == `SMC_SPAN_16G);
    endfunction
    function automatic logic [1:0] span_idx(input logic [3:0] c);
        case (c)
            `SMC_SPAN_4G:  span_idx = 2'h1;
            `SMC_SPAN_8G:  span_idx = 2'h2;
            `SMC_SPAN_16G: span_idx = 2'h3;
            default:       span_idx = 2'h0;
        endcase
    endfunction
    function automatic logic mode_ok(input logic [2:0] m);
        mode_ok = (m == 3'h0) | (m == 3'h1) | (m == 3'h2) | (m == 3'h4);
    endfunction

    // =====================================================================
    // write decode
    wire wr_span  = i_wr & (i_addr == `SMC_OFS_SPAN) & span_ok(i_wdata[3:0]);
    wire wr_filt  = i_wr & (i_addr == `SMC_OFS_FILT);
    wire wr_pwr   = i_wr & (i_addr == `SMC_OFS_PWR) & mode_ok(i_wdata[7:5]);
    wire wr_prof  = i_wr & (i_addr == `SMC_OFS_PROF);
    wire wr_ofmt  = i_wr & (i_addr == `SMC_OFS_OFMT);
    wire wr_eng   = i_wr & (i_addr == `SMC_OFS_ENG0);
    wire rst_trig = i_wr & (i_addr == `SMC_OFS_RST) & (i_wdata == `SMC_RST_KEY);
    wire rst_done = (rs_r == SMC_RS_WAIT) & (rcnt_r == 16'(RST_CYC - 1));

    // =====================================================================
    // read mux, reset trigger reads zero
    logic [7:0] rmux;
    always_comb begin
        case (i_addr)
            `SMC_OFS_SPAN: rmux = span_r;
            `SMC_OFS_FILT: rmux = filt_r;
            `SMC_OFS_PWR:  rmux = pwr_r;
            `SMC_OFS_PROF: rmux = prof_r;
            `SMC_OFS_OFMT: rmux = ofmt_r;
            `SMC_OFS_ENG0: rmux = eng_r;
            default:       rmux = 8'h00;
        endcase
    end

    // =====================================================================
    // bandwidth and mode decode
    wire [4:0] bwc = filt_r[4:0];
    wire [3:0] bw_nxt = bwc[4] ? 4'h7 :
                        (bwc[3] ? {1'b0, bwc[2:0]} : 4'h0);
    wire [2:0] mb = pwr_r[7:5];
    wire [1:0] mode_nxt = mb[2] ? SMC_HALT : (mb[1] ? SMC_DUTY :
                          (mb[0] ? SMC_DEEP : SMC_NORMAL));
    wire [3:0] nap_nxt = (pwr_r[3:0] < 4'h6) ? 4'h0 : (pwr_r[3:0] - 4'h5);
    wire low_mode = (mode_nxt == SMC_HALT) | (mode_nxt == SMC_DUTY);
    wire prof2    = prof_r[`SMC_BIT_PROF];

    // =====================================================================
    // register writes and soft reset restore
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            span_r <= `SMC_RST_SPAN;
            filt_r <= `SMC_RST_FILT;
            pwr_r  <= `SMC_RST_ZERO;
            prof_r <= `SMC_RST_ZERO;
            ofmt_r <= `SMC_RST_ZERO;
            eng_r  <= `SMC_RST_ZERO;
        end else if (rst_done) begin
            span_r <= `SMC_RST_SPAN;
            filt_r <= `SMC_RST_FILT;
            pwr_r  <= `SMC_RST_ZERO;
            prof_r <= `SMC_RST_ZERO;
            ofmt_r <= `SMC_RST_ZERO;
            eng_r  <= `SMC_RST_ZERO;
        end else begin
            if (wr_span) span_r <= i_wdata & `SMC_MASK_SPAN;
            if (wr_filt) filt_r <= i_wdata & `SMC_MASK_FILT;
            if (wr_pwr)  pwr_r  <= i_wdata;
            if (wr_prof) prof_r <= i_wdata & `SMC_MASK_PROF;
            if (wr_ofmt) ofmt_r <= i_wdata & `SMC_MASK_OFMT;
            if (wr_eng)  eng_r  <= i_wdata & `SMC_MASK_ENG0;
        end
    end

    // =====================================================================
    // soft reset delay sequencer
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rs_r   <= SMC_RS_IDLE;
            rcnt_r <= 16'h0000;
        end else begin
            case (rs_r)
                SMC_RS_IDLE: begin
                    rcnt_r <= 16'h0000;
                    if (rst_trig) rs_r <= SMC_RS_WAIT;
                end
                SMC_RS_WAIT: begin
                    rcnt_r <= rcnt_r + 16'h0001;
                    if (rst_done) rs_r <= SMC_RS_IDLE;
                end
                default: rs_r <= SMC_RS_IDLE;
            endcase
        end
    end

    // =====================================================================
    // read data and registered outputs
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_r       <= 8'h00;
            o_span_sel    <= 2'h0;
            o_bw_sel      <= 4'h0;
            o_mode        <= SMC_NORMAL;
            o_nap_sel     <= 4'h0;
            o_buf_access  <= 1'b1;
            o_slow_writes <= 1'b0;
            o_equidistant <= 1'b0;
            o_rst_busy    <= 1'b0;
            o_eng_en      <= 4'h0;
            o_slope_en    <= 3'h0;
        end else begin
            rdata_r       <= i_rd ? rmux : 8'h00;
            o_span_sel    <= span_idx(span_r[3:0]);
            o_bw_sel      <= bw_nxt;
            o_mode        <= mode_nxt;
            o_nap_sel     <= nap_nxt;
            o_buf_access  <= ~low_mode | prof2;
            o_slow_writes <= low_mode & ~prof2;
            o_equidistant <= prof_r[`SMC_BIT_TBASE];
            o_rst_busy    <= (rs_r == SMC_RS_WAIT) & ~rst_done;
            o_eng_en      <= eng_r[7:4];
            o_slope_en    <= eng_r[2:0];
        end
    end
    assign o_rdata = rdata_r;

    // =====================================================================
    // raw or filtered sample, then read-out lock
    wire [7:0] hi_live = ofmt_r[`SMC_BIT_RAW] ? i_hi_raw : i_hi_filt;
    logic hi_frozen;
    smc_axis_lock #(.W(8)) u_lock (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_lock_en  (~ofmt_r[`SMC_BIT_LOCKDIS]),
        .i_lo_rd    (i_lo_rd),
        .i_hi_rd    (i_hi_rd),
        .i_hi_live  (hi_live),
        .o_hi       (o_hi_byte),
        .o_frozen   (hi_frozen)
    );

    // =====================================================================
    // assertions
    a_key_starts: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        rst_trig && rs_r == SMC_RS_IDLE |=> rs_r == SMC_RS_WAIT)
        else $error("reset key did not start reset");
    a_nonkey_ignored: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        rs_r == SMC_RS_IDLE && !rst_trig |=> rs_r == SMC_RS_IDLE)
        else $error("reset started without key");
    a_restore_span: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        rst_done |=> span_r == `SMC_RST_SPAN && filt_r == `SMC_RST_FILT && eng_r == 8'h00)
        else $error("defaults not restored");
    a_span_legal: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        span_ok(span_r[3:0]))
        else $error("reserved span stored");
    a_mode_legal: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        mode_ok(pwr_r[7:5]))
        else $error("illegal mode stored");
    a_profile_buf: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        low_mode && !prof2 |=> !o_buf_access && o_slow_writes)
        else $error("first profile buffer not denied");
    a_profile_two: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        prof2 |=> o_buf_access && !o_slow_writes)
        else $error("second profile buffer denied");
    a_bw_top: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        filt_r[4] |=> o_bw_sel == 4'h7)
        else $error("bandwidth top code wrong");
    a_slope_rsvd: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        wr_eng && !rst_done |=> eng_r[3] == 1'b0 ##1 o_slope_en == $past(i_wdata[2:0], 2))
        else $error("slope enable wrong");
    a_lock_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
        hi_frozen && !i_hi_rd && !ofmt_r[`SMC_BIT_LOCKDIS] |=> $stable(o_hi_byte))
        else $error("locked high byte changed");
    c_soft_reset: cover property (@(posedge i_core_clk) disable iff (!i_rstn) rst_done);
    c_duty_mode: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
        o_mode == SMC_DUTY);
    c_lock: cover property (@(posedge i_core_clk) disable iff (!i_rstn) hi_frozen ##1 i_hi_rd);
endmodule

// ### smc_consts.svh
// offsets, field positions, reset values and timing counts of the mode config bank
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH
// =====================================================================
// register offsets
`define SMC_OFS_SPAN        8'h0F
`define SMC_OFS_FILT        8'h10
`define SMC_OFS_PWR         8'h11
`define SMC_OFS_PROF        8'h12
`define SMC_OFS_OFMT        8'h13
`define SMC_OFS_RST         8'h14
`define SMC_OFS_ENG0        8'h16
// =====================================================================
// reset values
`define SMC_RST_SPAN        8'h03
`define SMC_RST_FILT        8'h0F
`define SMC_RST_ZERO        8'h00
// =====================================================================
// codes and masks
`define SMC_SPAN_2G         4'h3
`define SMC_SPAN_4G         4'h5
`define SMC_SPAN_8G         4'h8
`define SMC_SPAN_16G        4'hC
`define SMC_RST_KEY         8'hB6
`define SMC_MASK_SPAN       8'h0F
`define SMC_MASK_FILT       8'h1F
`define SMC_MASK_PROF       8'h60
`define SMC_MASK_OFMT       8'hC0
`define SMC_MASK_ENG0       8'hF7
// =====================================================================
// field positions
`define SMC_BIT_HALT        7
`define SMC_BIT_DUTY        6
`define SMC_BIT_DEEP        5
`define SMC_BIT_PROF        6
`define SMC_BIT_TBASE       5
`define SMC_BIT_RAW         7
`define SMC_BIT_LOCKDIS     6
// =====================================================================
// soft reset delay: time in ns, cycles at 100 ns clock
`define SMC_RST_DELAY_NS    2000
`define SMC_CLK_NS          100
`define SMC_RST_DELAY_CYC   ((`SMC_RST_DELAY_NS + `SMC_CLK_NS - 1) / `SMC_CLK_NS)
`endif

// ### smc_pkg.sv
// types of the mode config bank
package smc_pkg;
    // power mode of the sensor
    typedef enum logic [1:0] {
        SMC_NORMAL = 2'b00,
        SMC_DEEP   = 2'b01,
        SMC_DUTY   = 2'b10,
        SMC_HALT   = 2'b11
    } smc_mode_t;
    // soft reset sequencer
    typedef enum logic [0:0] {
        SMC_RS_IDLE = 1'b0,
        SMC_RS_WAIT = 1'b1
    } smc_rst_state_t;
endpackage

// ### smc_axis_lock.sv
// read-out lock of one axis high byte
`timescale 1ns/1ps
`include "smc_consts.svh"
module smc_axis_lock #(
    parameter int W = 8
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_rstn,
    input  wire logic         i_lock_en,   // locking enabled
    input  wire logic         i_lo_rd,     // low byte read
    input  wire logic         i_hi_rd,     // high byte read
    input  wire logic [W-1:0] i_hi_live,   // live high byte
    output logic      [W-1:0] o_hi,        // presented high byte
    output logic              o_frozen     // freeze active
);
    // =====================================================================
    // freeze flag and held byte
    logic         frz_r;
    logic [W-1:0] hold_r;
    logic         frz_nxt;
    assign frz_nxt = i_lock_en & (i_lo_rd | (frz_r & ~i_hi_rd));
    // update held byte when not frozen or when locking is disabled
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            frz_r  <= 1'b0;
            hold_r <= '0;
        end else begin
            frz_r <= frz_nxt;
            if (!frz_r | !i_lock_en) begin
                hold_r <= i_hi_live;
            end
        end
    end
    assign o_hi     = hold_r;
    assign o_frozen = frz_r;
endmodule

// ### smc_host_model.sv
// host model that drives the register port of the mode config bank
`timescale 1ns/1ps
module smc_host_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_rdata,
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    // ==========================================================
    // idle bus at time zero
    initial begin
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    // ==========================================================
    // one-cycle write; released lines show inverted data, not the old value
    // callers also write one illegal span code and one illegal mode value, which must be ignored
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_core_clk);
        o_wr    <= 1'b0;
        o_addr  <= ~a;
        o_wdata <= ~d;
    endtask
    // one-cycle read; data taken in the cycle after the strobe only
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_core_clk);
        o_rd   <= 1'b0;
        o_addr <= ~a;
        #1;
        d = i_rdata;
    endtask
endmodule

// ### tb_top.sv
// self-checking bench of the mode config register bank
`timescale 1ns/1ps
module tb_top
    import smc_pkg::*;
;
    logic       clk, rstn, lo_rd, hi_rd;
    logic [7:0] filt, raw, v, d;
    wire  [7:0] addr, wdata, rdata, hi_byte;
    wire        wr, rd, buf_acc, slow_wr, equid, rst_busy;
    wire  [1:0] span_sel, mode;
    wire  [3:0] bw_sel, nap_sel, eng_en;
    wire  [2:0] slope_en;
    int         failures, comparisons, seed, i;
    logic [7:0] ofs[8]  = '{8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h15};
    logic [7:0] dflt[8] = '{8'h03, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] spc[4]  = '{8'h03, 8'h05, 8'h08, 8'h0C};
    logic [7:0] pm[4]   = '{8'h00, 8'h20, 8'h40, 8'h80};
    // ==========================================================
    // clock of 100 ns period
    initial clk = 1'b0;
    always #50 clk = ~clk;
    smc_host_model smc_host_model_inst (.i_core_clk(clk), .i_rdata(rdata), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    // short soft reset delay keeps the run brief
    smc_regs #(.RST_CYC(3)) smc_regs_inst (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_lo_rd(lo_rd), .i_hi_rd(hi_rd),
        .i_hi_filt(filt), .i_hi_raw(raw), .o_rdata(rdata), .o_span_sel(span_sel),
        .o_bw_sel(bw_sel), .o_mode(mode), .o_nap_sel(nap_sel), .o_buf_access(buf_acc),
        .o_slow_writes(slow_wr), .o_equidistant(equid), .o_hi_byte(hi_byte),
        .o_rst_busy(rst_busy), .o_eng_en(eng_en), .o_slope_en(slope_en));
    // ==========================================================
    // expected bandwidth index and nap index
    function automatic logic [7:0] bw_exp(input logic [4:0] c);
        return c[4] ? 8'h07 : (c[3] ? {5'h00, c[2:0]} : 8'h00);
    endfunction
    function automatic logic [7:0] nap_exp(input logic [3:0] n);
        return (n <= 4'h5) ? 8'h00 : {4'h0, n - 4'h5};
    endfunction
    // ==========================================================
    // compare, count and report
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // write, then let decoded outputs settle one more cycle
    task automatic wrc(input logic [7:0] a, input logic [7:0] dd);
        smc_host_model_inst.wr(a, dd);
        cyc(1);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
        smc_host_model_inst.rd(a, v);
        chk(nm, v, exp);
    endtask
    task automatic chk_defaults();
        foreach (ofs[k]) rdchk("default", ofs[k], dflt[k]);
    endtask
    // one-cycle pulse on the low or high byte read line
    task automatic pulse(input bit high);
        @(posedge clk);
        if (high) hi_rd <= 1'b1; else lo_rd <= 1'b1;
        @(posedge clk);
        hi_rd <= 1'b0;
        lo_rd <= 1'b0;
    endtask
    task automatic wait_busy(input logic lvl);
        for (i = 0; i < 20 && rst_busy !== lvl; i++) cyc(1);
        if (rst_busy !== lvl) begin
            failures++;
            tally_and_finish();
        end
    endtask
    // ==========================================================
    // main sequence
    initial begin
        rstn = 1'b0;
        lo_rd = 1'b0;
        hi_rd = 1'b0;
        filt = 8'h00;
        raw = 8'h00;
        seed = $urandom(92);
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        cyc(2);
        chk_defaults();
        $display("test reset_values done");
        foreach (spc[k]) begin
            wrc(8'h0F, spc[k]);
            chk("span", {6'h00, span_sel}, 8'(k));
        end
        wrc(8'h0F, 8'h07);
        chk("span_keep", {6'h00, span_sel}, 8'h03);
        $display("test span done");
        for (int c = 0; c < 32; c++) begin
            wrc(8'h10, 8'(c) | 8'hE0);
            chk("bw", {4'h0, bw_sel}, bw_exp(5'(c)));
            rdchk("bw_rb", 8'h10, 8'(c));
        end
        $display("test bandwidth done");
        foreach (pm[k]) begin
            wrc(8'h11, pm[k]);
            chk("mode", {6'h00, mode}, 8'(k));
        end
        for (int n = 0; n < 16; n++) begin
            wrc(8'h11, 8'h40 | 8'(n));
            chk("nap", {4'h0, nap_sel}, nap_exp(4'(n)));
        end
        wrc(8'h11, 8'hE0);
        chk("mode_keep", {6'h00, mode}, {6'h00, SMC_DUTY});
        $display("test power done");
        for (int p = 0; p < 4; p++) begin
            wrc(8'h12, 8'(p << 5));
            chk("buf", {7'h00, buf_acc}, {7'h00, p[1]});
            chk("slow", {7'h00, slow_wr}, {7'h00, ~p[1]});
            chk("equid", {7'h00, equid}, {7'h00, p[0]});
        end
        wrc(8'h11, 8'h80);
        wrc(8'h12, 8'h00);
        chk("buf_halt", {7'h00, buf_acc}, 8'h00);
        $display("test profile done");
        d = 8'($urandom);
        @(posedge clk);
        filt <= d;
        raw <= ~d;
        wrc(8'h13, 8'h80);
        chk("raw", hi_byte, ~d);
        wrc(8'h13, 8'h00);
        chk("filt", hi_byte, d);
        pulse(1'b0);
        filt <= d + 8'h11;
        cyc(3);
        chk("frozen", hi_byte, d);
        pulse(1'b1);
        cyc(2);
        chk("released", hi_byte, d + 8'h11);
        wrc(8'h13, 8'h40);
        pulse(1'b0);
        filt <= d;
        cyc(3);
        chk("unlocked", hi_byte, d);
        $display("test output_format done");
        repeat (8) begin
            d = 8'($urandom);
            wrc(8'h16, d);
            chk("eng", {4'h0, eng_en}, {4'h0, d[7:4]});
            chk("slope", {5'h00, slope_en}, {5'h00, d[2:0]});
            rdchk("eng_rb", 8'h16, d & 8'hF7);
        end
        $display("test engines done");
        d = 8'($urandom);
        wrc(8'h14, (d == 8'hB6) ? 8'h00 : d);
        cyc(3);
        chk("no_reset", {7'h00, rst_busy}, 8'h00);
        chk("mode_held", {6'h00, mode}, {6'h00, SMC_HALT});
        smc_host_model_inst.wr(8'h14, 8'hB6);
        wait_busy(1'b1);
        wait_busy(1'b0);
        cyc(1);
        chk_defaults();
        chk("mode_dflt", {6'h00, mode}, 8'h00);
        // span lost by the reset is programmed again
        wrc(8'h0F, 8'h05);
        chk("span_again", {6'h00, span_sel}, 8'h01);
        $display("test soft_reset done");
        tally_and_finish();
    end
endmodule
